// ---- src/ossd_pkg.sv ----
// ossd_pkg: register map, field layouts, reset values and timing counts
// of the main clock selector with oscillation stop detection.
// assumes a 20 MHz system clock and a 32-bit register bus.
package ossd_pkg;

    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_CFG = 5'h00;
    localparam logic [4:0] OFS_BITOP = 5'h04;
    localparam logic [4:0] OFS_OSD = 5'h08;
    localparam logic [4:0] OFS_IRQ_ST = 5'h0C;
    localparam logic [4:0] OFS_IRQ_MSK = 5'h10;

    // ------------------------------------------------------------
    // processor configuration register fields
    // ------------------------------------------------------------
    localparam logic [1:0] DIV_HIGH = 2'h0;   // external / 2
    localparam logic [1:0] DIV_MID = 2'h1;    // external / 8
    localparam logic [1:0] DIV_RING = 2'h2;   // ring / 8
    localparam logic [1:0] DIV_DOUBLE = 2'h3; // external / 1
    // bits 5, 1, 0 are write-once
    localparam logic [7:0] CFG_LOCK_MASK = 8'h23;
    // ring middle speed, both oscillators running
    localparam logic [7:0] CFG_RESET = 8'h80;

    // divider terminal counts (ratio minus one)
    localparam logic [2:0] RATIO_1 = 3'h0;
    localparam logic [2:0] RATIO_2 = 3'h1;
    localparam logic [2:0] RATIO_8 = 3'h7;

    // bit operation register fields
    localparam int BITOP_VAL = 3;

    // ------------------------------------------------------------
    // stop detector control register fields
    // ------------------------------------------------------------
    localparam int OSD_ACTIVE = 0;
    localparam int OSD_STATUS = 4;
    localparam int OSD_LOCK = 5;

    // interrupt status and mask layout
    localparam int IRQ_W = 2;
    localparam int IRQ_STOP = 0;
    localparam int IRQ_TO_RING = 1;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    // external oscillator silent this long counts as stopped
    localparam int STOP_TIME_NS = 10000;
    localparam int STOP_CYC = (STOP_TIME_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
    localparam int STOP_W = $clog2(STOP_CYC + 1);
    // length of the internal reset pulse
    localparam int INT_RST_NS = 200;
    localparam int INT_RST_CYC = (INT_RST_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] div;
        logic rc_mode;
        logic xin_stop;
        logic ring_stop;
        logic spare;
        logic [1:0] pmode;
    } ossd_cfg_type;

    typedef struct packed {
        logic stab_en;
        logic rst_en;
        logic active;
    } ossd_osd_type;

endpackage

// ---- src/ossd_div.sv ----
// ossd_div: divides a stream of source ticks down to the cpu tick.
// assumes source ticks are one-cycle pulses on clk_sys_in.
`timescale 1ns/1ps
module ossd_div (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic restart_in,
    input wire logic src_tick_in,
    input wire logic [2:0] ratio_in,
    output logic tick_out
);

    // ------------------------------------------------------------
    // tick counter
    // ------------------------------------------------------------
    logic [2:0] cnt_ff;
    logic wrap;

    assign wrap = (cnt_ff >= ratio_in);

    // restart keeps the first tick after a switch a full period away
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_ff <= 3'h0;
        end else if (restart_in) begin
            cnt_ff <= 3'h0;
        end else if (src_tick_in) begin
            if (wrap) begin
                cnt_ff <= 3'h0;
            end else begin
                cnt_ff <= cnt_ff + 3'h1;
            end
        end
    end

    // registered output tick
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= src_tick_in & wrap & ~restart_in;
        end
    end

endmodule

// ---- src/ossd_ctrl.sv ----
// ossd_ctrl: main clock selection, division and oscillation stop
// detection, with its registers on an avalon-mm slave.
// assumes the external oscillator arrives as a level on xin_in that is
// asynchronous to clk_sys_in and much slower than it.
`timescale 1ns/1ps
module ossd_ctrl #(
    parameter int RING_DIV = 2
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic xin_in,
    output logic cpu_clk_tick_out,
    output logic clk_src_ring_out,
    output logic xin_osc_en_out,
    output logic ring_osc_en_out,
    output logic xin_rc_mode_out,
    output logic [1:0] proc_mode_out,
    output logic stab_en_out,
    output logic int_rst_out,
    output logic irq_out
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam int RING_W = $clog2(RING_DIV + 1);

    ossd_pkg::ossd_cfg_type cfg_ff;
    ossd_pkg::ossd_cfg_type nxt_cfg;
    ossd_pkg::ossd_osd_type osd_ff;
    logic lock_ff;
    logic nxt_lock;
    logic status_ff;
    logic [ossd_pkg::IRQ_W-1:0] ist_ff;
    logic [ossd_pkg::IRQ_W-1:0] imsk_ff;
    logic [ossd_pkg::IRQ_W-1:0] nxt_ist;
    logic [ossd_pkg::IRQ_W-1:0] nxt_imsk;
    logic [ossd_pkg::IRQ_W-1:0] irq_set;
    logic wait_ff;
    logic [31:0] rdata_ff;
    logic [31:0] rd_mux;
    logic [2:0] xin_sync_ff;
    logic xin_filt_ff;
    logic xin_rise_ff;
    logic [ossd_pkg::STOP_W-1:0] stop_cnt_ff;
    logic [2:0] int_cnt_ff;
    logic int_rst_ff;
    logic [RING_W-1:0] ring_cnt_ff;
    logic ring_tick_ff;
    logic src_ring_q_ff;
    logic req;
    logic acc;
    logic wr_cfg;
    logic wr_bitop;
    logic wr_osd;
    logic wr_ist;
    logic wr_imsk;
    logic [2:0] bit_idx;
    logic src_ring;
    logic src_tick;
    logic [2:0] ratio;
    logic monitor;
    logic stop_hit;
    logic to_ring;

    // ------------------------------------------------------------
    // external oscillator pin
    // ------------------------------------------------------------
    // three stages; only the last two are compared, so the first
    // stage never feeds logic other than the second
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            xin_sync_ff <= 3'h0;
        end else begin
            xin_sync_ff <= {xin_sync_ff[1:0], xin_in};
        end
    end

    // filtered level changes only when stages two and three agree
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            xin_filt_ff <= 1'b0;
            xin_rise_ff <= 1'b0;
        end else begin
            if (xin_sync_ff[2] == xin_sync_ff[1]) begin
                xin_filt_ff <= xin_sync_ff[2];
            end
            xin_rise_ff <= xin_sync_ff[2] & xin_sync_ff[1] & ~xin_filt_ff;
        end
    end

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    // one wait cycle per access; request taken when wait_ff is low
    assign req = avs_read_in | avs_write_in;
    assign acc = req & ~wait_ff;
    assign bit_idx = avs_writedata_in[2:0];

    assign wr_cfg = acc & avs_write_in & avs_byteenable_in[0]
                    & (avs_address_in == ossd_pkg::OFS_CFG);
    assign wr_bitop = acc & avs_write_in & avs_byteenable_in[0]
                      & (avs_address_in == ossd_pkg::OFS_BITOP);
    assign wr_osd = acc & avs_write_in & avs_byteenable_in[0]
                    & (avs_address_in == ossd_pkg::OFS_OSD);
    assign wr_ist = acc & avs_write_in & avs_byteenable_in[0]
                    & (avs_address_in == ossd_pkg::OFS_IRQ_ST);
    assign wr_imsk = acc & avs_write_in & avs_byteenable_in[0]
                     & (avs_address_in == ossd_pkg::OFS_IRQ_MSK);

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= ~(req & wait_ff);
        end
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        rd_mux = 32'h0;
        unique case (avs_address_in)
            ossd_pkg::OFS_CFG: begin
                rd_mux = {24'h0, cfg_ff};
            end
            ossd_pkg::OFS_OSD: begin
                rd_mux = {26'h0, lock_ff, status_ff, 1'b0, osd_ff};
            end
            ossd_pkg::OFS_IRQ_ST: begin
                rd_mux = {30'h0, ist_ff};
            end
            ossd_pkg::OFS_IRQ_MSK: begin
                rd_mux = {30'h0, imsk_ff};
            end
            default: begin
                rd_mux = 32'h0;
            end
        endcase
    end

    // read data captured in the wait cycle, standing at the accept edge
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_ff <= 32'h0;
        end else if (avs_read_in & wait_ff) begin
            rdata_ff <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // processor configuration register
    // ------------------------------------------------------------
    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_lock = lock_ff;
        if (wr_cfg) begin
            nxt_cfg = avs_writedata_in[7:0];
            if (lock_ff) begin
                // locked bits keep their value, others take the write
                nxt_cfg = (avs_writedata_in[7:0] & ~ossd_pkg::CFG_LOCK_MASK)
                          | (cfg_ff & ossd_pkg::CFG_LOCK_MASK);
            end
            nxt_lock = 1'b1;
        end else if (wr_bitop) begin
            // single bit set or clear, as a read-modify-write
            if (!(lock_ff && ossd_pkg::CFG_LOCK_MASK[bit_idx])) begin
                nxt_cfg[bit_idx] = avs_writedata_in[ossd_pkg::BITOP_VAL];
            end
            nxt_lock = 1'b1;
        end
        // stopping the external source under the cpu would hang it;
        // fall back to ring middle speed instead
        if (nxt_cfg.xin_stop && nxt_cfg.div != ossd_pkg::DIV_RING) begin
            nxt_cfg.div = ossd_pkg::DIV_RING;
        end
    end

    // internal reset restores the config and reopens the lock
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_ff <= ossd_pkg::CFG_RESET;
            lock_ff <= 1'b0;
        end else if (int_rst_ff) begin
            cfg_ff <= ossd_pkg::CFG_RESET;
            lock_ff <= 1'b0;
        end else begin
            cfg_ff <= nxt_cfg;
            lock_ff <= nxt_lock;
        end
    end

    // ------------------------------------------------------------
    // stop detector control and status
    // ------------------------------------------------------------
    // only the external reset touches these, so detection carries
    // on through its own internal reset
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            osd_ff <= 3'h0;
        end else if (wr_osd) begin
            osd_ff <= avs_writedata_in[2:0];
        end
    end

    // status flag; a detection in the clearing cycle wins
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            status_ff <= 1'b0;
        end else if (stop_hit) begin
            status_ff <= 1'b1;
        end else if (wr_osd && !avs_writedata_in[ossd_pkg::OSD_ACTIVE]) begin
            status_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // oscillation stop detection
    // ------------------------------------------------------------
    // watch only while the detector is on and the source is running
    assign monitor = osd_ff.active & ~cfg_ff.xin_stop & ~int_rst_ff;
    assign stop_hit = monitor & ~xin_rise_ff & (stop_cnt_ff ==
                      ossd_pkg::STOP_W'(ossd_pkg::STOP_CYC - 1));

    // counts cycles since the last rising edge; parks at the limit so
    // one silent stretch gives one detection, repeated after each internal reset when rst_en is set
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            stop_cnt_ff <= '0;
        end else if (!monitor || xin_rise_ff) begin
            stop_cnt_ff <= '0;
        end else if (stop_cnt_ff!=ossd_pkg::STOP_W'(ossd_pkg::STOP_CYC)) begin
            stop_cnt_ff <= stop_cnt_ff + ossd_pkg::STOP_W'(1);
        end
    end

    // internal reset pulse, only when stop reset is enabled
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            int_cnt_ff <= 3'h0;
            int_rst_ff <= 1'b0;
        end else if (stop_hit && osd_ff.rst_en) begin
            int_cnt_ff <= 3'(ossd_pkg::INT_RST_CYC - 1);
            int_rst_ff <= 1'b1;
        end else if (int_cnt_ff != 3'h0) begin
            int_cnt_ff <= int_cnt_ff - 3'h1;
            int_rst_ff <= 1'b1;
        end else begin
            int_rst_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // ring oscillator model
    // ------------------------------------------------------------
    // the ring runs as a tick every RING_DIV system cycles while on
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ring_cnt_ff <= '0;
            ring_tick_ff <= 1'b0;
        end else if (cfg_ff.ring_stop) begin
            ring_cnt_ff <= '0;
            ring_tick_ff <= 1'b0;
        end else if (ring_cnt_ff == RING_W'(RING_DIV - 1)) begin
            ring_cnt_ff <= '0;
            ring_tick_ff <= 1'b1;
        end else begin
            ring_cnt_ff <= ring_cnt_ff + RING_W'(1);
            ring_tick_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // clock source and division
    // ------------------------------------------------------------
    // a stopped external source gives no ticks, so a cpu on it halts
    assign src_ring = (cfg_ff.div == ossd_pkg::DIV_RING);
    assign src_tick = src_ring ? ring_tick_ff
                               : (xin_rise_ff & ~cfg_ff.xin_stop);

    always_comb begin
        ratio = ossd_pkg::RATIO_8;
        unique case (cfg_ff.div)
            ossd_pkg::DIV_DOUBLE: begin
                ratio = ossd_pkg::RATIO_1;
            end
            ossd_pkg::DIV_HIGH: begin
                ratio = ossd_pkg::RATIO_2;
            end
            ossd_pkg::DIV_MID: begin
                ratio = ossd_pkg::RATIO_8;
            end
            ossd_pkg::DIV_RING: begin
                ratio = ossd_pkg::RATIO_8;
            end
        endcase
    end

    // remembers the previous source to spot a switch
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            src_ring_q_ff <= 1'b1;
        end else begin
            src_ring_q_ff <= src_ring;
        end
    end

    ossd_div u_div (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .restart_in(int_rst_ff | (src_ring != src_ring_q_ff)),
        .src_tick_in(src_tick),
        .ratio_in(ratio),
        .tick_out(cpu_clk_tick_out)
    );

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    assign to_ring = src_ring & ~src_ring_q_ff;
    assign irq_set = {to_ring, stop_hit};

    // write one to clear; a new event in the same cycle stays set
    always_comb begin
        nxt_ist = ist_ff;
        if (wr_ist) begin
            nxt_ist = ist_ff & ~avs_writedata_in[ossd_pkg::IRQ_W-1:0];
        end
        nxt_ist = nxt_ist | irq_set;
        nxt_imsk = wr_imsk ? avs_writedata_in[ossd_pkg::IRQ_W-1:0]
                           : imsk_ff;
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ist_ff <= '0;
            imsk_ff <= '0;
            irq_out <= 1'b0;
        end else begin
            ist_ff <= nxt_ist;
            imsk_ff <= nxt_imsk;
            irq_out <= |(nxt_ist & nxt_imsk);
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            clk_src_ring_out <= 1'b1;
            xin_osc_en_out <= 1'b1;
            ring_osc_en_out <= 1'b1;
            xin_rc_mode_out <= 1'b0;
            proc_mode_out <= 2'h0;
            stab_en_out <= 1'b0;
            int_rst_out <= 1'b0;
        end else begin
            clk_src_ring_out <= src_ring;
            xin_osc_en_out <= ~cfg_ff.xin_stop;
            ring_osc_en_out <= ~cfg_ff.ring_stop;
            xin_rc_mode_out <= cfg_ff.rc_mode;
            proc_mode_out <= cfg_ff.pmode;
            stab_en_out <= osd_ff.stab_en;
            int_rst_out <= int_rst_ff;
        end
    end

    assign avs_waitrequest_out = wait_ff;
    assign avs_readdata_out = rdata_ff;

endmodule

// ---- dv/ossd_ctrl_sva.sv ----
// ossd_ctrl_sva: port-level checks of the main clock selector.
// assumes it is bound into each ossd_ctrl and sees only its ports.
`timescale 1ns/1ps
module ossd_ctrl_sva (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic xin_in,
    input wire logic cpu_clk_tick_out,
    input wire logic clk_src_ring_out,
    input wire logic xin_osc_en_out,
    input wire logic ring_osc_en_out,
    input wire logic xin_rc_mode_out,
    input wire logic [1:0] proc_mode_out,
    input wire logic stab_en_out,
    input wire logic int_rst_out,
    input wire logic irq_out
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    // a new request waits one cycle, then is taken
    property p_req_wait;
        $rose(avs_read_in || avs_write_in) |->
            avs_waitrequest_out ##1 !avs_waitrequest_out;
    endproperty
    property p_wait_one;
        !avs_waitrequest_out |=> avs_waitrequest_out;
    endproperty
    // the stop reset is a fixed four-cycle pulse
    property p_int_rst_len;
        $rose(int_rst_out) |-> int_rst_out[*4] ##1 !int_rst_out;
    endproperty
    property p_int_ring;
        $fell(int_rst_out) |-> ##[0:2] (clk_src_ring_out && xin_osc_en_out);
    endproperty
    property p_reset_ring;
        $fell(rst_in) |-> clk_src_ring_out && !cpu_clk_tick_out;
    endproperty
    // a stopped external source can never be the cpu source
    property p_xin_off;
        !xin_osc_en_out |-> clk_src_ring_out;
    endproperty
    property p_tick_pulse;
        cpu_clk_tick_out |=> !cpu_clk_tick_out;
    endproperty
    // ring /8 keeps at least eight cycles between ticks
    property p_ring_gap;
        cpu_clk_tick_out && clk_src_ring_out |=>
            (!cpu_clk_tick_out || !clk_src_ring_out)[*7];
    endproperty

    a_req_wait: assert property (p_req_wait) // bus
        else $error("request not taken after one wait cycle");
    a_wait_one: assert property (p_wait_one) // bus
        else $error("waitrequest low for more than one cycle");
    a_int_rst_len: assert property (p_int_rst_len)
        else $error("internal reset pulse length wrong");
    a_int_ring: assert property (p_int_ring)
        else $error("ring not selected after internal reset");
    a_reset_ring: assert property (p_reset_ring)
        else $error("ring not the source at reset release");
    a_xin_off: assert property (p_xin_off)
        else $error("stopped external source still selected");
    a_tick_pulse: assert property (p_tick_pulse)
        else $error("cpu tick wider than one cycle");
    a_ring_gap: assert property (p_ring_gap)
        else $error("ring ticks too close together");

    c_int_rst: cover property ($rose(int_rst_out));
    c_irq: cover property ($rose(irq_out));
    c_ext_tick: cover property (cpu_clk_tick_out && !clk_src_ring_out);
endmodule

bind ossd_ctrl ossd_ctrl_sva u_sva (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .xin_in(xin_in),
    .cpu_clk_tick_out(cpu_clk_tick_out),
    .clk_src_ring_out(clk_src_ring_out), .xin_osc_en_out(xin_osc_en_out),
    .ring_osc_en_out(ring_osc_en_out), .xin_rc_mode_out(xin_rc_mode_out),
    .proc_mode_out(proc_mode_out), .stab_en_out(stab_en_out),
    .int_rst_out(int_rst_out), .irq_out(irq_out));

// ---- dv/testbench.sv ----
// testbench: register-level tests of the main clock selector.
// assumes ossd_pkg, ossd_ctrl and the checker are compiled first.
`timescale 1ns/1ps
module testbench;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hF;
    logic crystal_input_pin = 1'b0;
    logic xrun = 1'b0;
    logic [3:0] xcnt = 4'h0;
    logic saw_rst = 1'b0;
    logic [31:0] rdat, q;
    logic wreq, tick, ring, xen, ren, rcm, stab, irst, irq;
    logic [1:0] pm;
    logic [1:0] dv [3] = '{2'h0, 2'h1, 2'h3};
    int en [3] = '{16, 4, 32};
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;

    always #25 clk_sys_in = ~clk_sys_in;

    ossd_ctrl #(.RING_DIV(2)) uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wd), .avs_byteenable_in(be),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .xin_in(crystal_input_pin),
        .cpu_clk_tick_out(tick), .clk_src_ring_out(ring),
        .xin_osc_en_out(xen), .ring_osc_en_out(ren), .xin_rc_mode_out(rcm),
        .proc_mode_out(pm), .stab_en_out(stab), .int_rst_out(irst),
        .irq_out(irq));

    // external source toggles every ten cycles while xrun is high
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (irst === 1'b1) begin
            saw_rst <= 1'b1;
        end
        if (xrun) begin
            xcnt <= (xcnt == 4'h9) ? 4'h0 : xcnt + 4'h1;
            if (xcnt == 4'h9) begin
                crystal_input_pin <= ~crystal_input_pin;
            end
        end
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one access; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        n = 0;
        @(posedge clk_sys_in);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (wreq !== 1'b0);
        // read data taken at the accept edge, before anything changes
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        check("wait cycles", 32'h2, n);
    endtask

    task automatic rdchk(input string nm, input logic [4:0] a,
                         input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(nm, e, q);
    endtask

    // tick count over a window, one tick of slack for phase
    task automatic tchk(input int len, input int e);
        int k;
        k = 0;
        repeat (len) begin
            @(negedge clk_sys_in);
            if (tick === 1'b1) k++;
        end
        if (k >= e - 1 && k <= e + 1) k = e;
        check("cpu ticks", e, k);
    endtask

    task automatic do_rst();
        rst_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        rst_in <= 1'b0;
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        do_rst();
        rdchk("cfg", ossd_pkg::OFS_CFG, 32'h80);
        check("src ring", 1'b1, ring);
        tchk(320, 20);
        rdchk("unmapped", 5'h14, 32'h0);
        xrun <= 1'b1;
        bus(1'b1, ossd_pkg::OFS_CFG, 32'hC1);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, ossd_pkg::OFS_CFG, {24'h0, dv[i], 6'h02});
            rdchk("cfg", ossd_pkg::OFS_CFG, {24'h0, dv[i], 6'h01});
            tchk(640, en[i]);
        end
        bus(1'b1, ossd_pkg::OFS_BITOP, 32'h0B);
        rdchk("cfg", ossd_pkg::OFS_CFG, 32'hC9);
        check("ring en", 1'b0, ren);
        bus(1'b1, ossd_pkg::OFS_BITOP, 32'h03);
        bus(1'b1, ossd_pkg::OFS_BITOP, 32'h0C);
        rdchk("cfg", ossd_pkg::OFS_CFG, 32'h91);
        check("xin en", 1'b0, xen);
        rdchk("irq st", ossd_pkg::OFS_IRQ_ST, 32'h2);
        bus(1'b1, ossd_pkg::OFS_IRQ_MSK, 32'h2);
        settle();
        check("irq", 1'b1, irq);
        bus(1'b1, ossd_pkg::OFS_IRQ_ST, 32'h2);
        settle();
        check("irq", 1'b0, irq);
        bus(1'b1, ossd_pkg::OFS_BITOP, 32'h04);
        be <= 4'hE;
        bus(1'b1, ossd_pkg::OFS_OSD, 32'h01);
        be <= 4'hF;
        rdchk("osd", ossd_pkg::OFS_OSD, 32'h20);
        bus(1'b1, ossd_pkg::OFS_OSD, 32'h01);
        xrun <= 1'b0;
        repeat (260) @(posedge clk_sys_in);
        rdchk("osd", ossd_pkg::OFS_OSD, 32'h31);
        check("no int rst", 1'b0, saw_rst);
        rdchk("irq st", ossd_pkg::OFS_IRQ_ST, 32'h1);
        bus(1'b1, ossd_pkg::OFS_OSD, 32'h00);
        rdchk("osd", ossd_pkg::OFS_OSD, 32'h20);
        bus(1'b1, ossd_pkg::OFS_OSD, 32'h07);
        n = 0;
        while (irst !== 1'b1 && n < 400) begin
            @(negedge clk_sys_in);
            n++;
        end
        check("int rst", 1'b1, irst);
        repeat (6) @(posedge clk_sys_in);
        bus(1'b1, ossd_pkg::OFS_CFG, 32'hA3);
        rdchk("cfg", ossd_pkg::OFS_CFG, 32'hA3);
        check("rc mode", 1'b1, rcm);
        check("proc mode", 2'h3, pm);
        check("stab", 1'b1, stab);
        rdchk("osd", ossd_pkg::OFS_OSD, 32'h37);
        do_rst();
        rdchk("osd", ossd_pkg::OFS_OSD, 32'h00);
        bus(1'b1, ossd_pkg::OFS_BITOP, 32'h0A);
        bus(1'b1, ossd_pkg::OFS_CFG, 32'hB7);
        rdchk("cfg", ossd_pkg::OFS_CFG, 32'h94);
        check("ring en", 1'b1, ren);
        end_sim();
    end
endmodule
